/* File: include/strap_consts.vh */
// constants for the reset strap and boot mode decoder
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH
// boot mode codes
`define MODE_HOST_NOLOOP 4'h0
`define MODE_TWI 4'h1
`define MODE_HOST_D2M32 4'h2
`define MODE_HOST_D2M12 4'h4
`define MODE_HOST_D1M12 4'h5
`define MODE_HOST_D3M12 4'h7
`define MODE_FLASH_NOLOOP 4'h8
`define MODE_FLASH_D1M17 4'h9
`define MODE_FLASH_D2M16 4'hA
`define MODE_FLASH_D3M18 4'hB
`define MODE_FLASH_ALT 4'hC
`define MODE_RESET 4'h0
// boot port encoding
`define PORT_RESERVED 3'h0
`define PORT_HOST 3'h1
`define PORT_FLASH_MAIN 3'h2
`define PORT_FLASH_ALT 3'h3
`define PORT_TWI 3'h4
// clock select encodings
`define SRC_SEL_00 2'h0
`define SRC_SEL_01 2'h1
`define SRC_SEL_11 2'h3
// divider and multiplier values
`define DIV_NONE 2'h0
`define DIV_1 2'h1
`define DIV_2 2'h2
`define DIV_3 2'h3
`define MUL_NONE 6'h00
`define MUL_12 6'h0C
`define MUL_16 6'h10
`define MUL_17 6'h11
`define MUL_18 6'h12
`define MUL_32 6'h20
`define TWI_CLK_DIV 8'h80
`define TWI_NO_DIV 8'h00
// strap level meanings
`define WDOG_ON 1'b1
`define STROBE_HIGH 1'b1
`define WIDTH_8BIT 1'b1
`define DUAL_STROBE 1'b1
`endif

/* File: core/sync2.v */
// two flip-flop synchroniser for one strap or reset level
`timescale 1ns/10ps
`default_nettype none
module sync2 (
   input wire core_clk, // system clock
   input wire arst_n, // asynchronous reset, active low
   input wire d, // asynchronous level
   output reg q // synchronised level
);
   reg meta_q;
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // sync2
`default_nettype wire

/* File: core/strap_decoder.v */
// reset strap capture and boot mode decoder
`timescale 1ns/10ps
`default_nettype none
`include "strap_consts.vh"
module strap_decoder (
   input wire core_clk, // input clock pin, loop bypassed
   input wire arst_n, // asynchronous reset, active low
   input wire power_on_reset_n, // power-on reset pin, active low
   input wire hard_reset_n, // hard reset pin, active low
   input wire [3:0] boot_mode_straps, // boot mode strap pins
   input wire watchdog_enable_strap, // watchdog strap pin
   input wire host_strobe_polarity_strap, // strobe polarity strap
   input wire host_width_strap, // host width strap
   input wire host_dual_strobe_strap, // dual/single strobe strap
   input wire loop_enable_sw, // boot software enables the loop
   output reg straps_valid, // straps captured since power-on
   output reg [3:0] boot_mode, // captured boot mode code
   output reg [2:0] boot_port, // decoded boot port
   output reg boot_mode_reserved, // captured code is reserved
   output reg [1:0] loop_divide, // loop input divider, 0 none
   output reg [5:0] loop_multiply, // loop multiplier, 0 none
   output reg [1:0] clock_source_select, // clock select field
   output reg loop_range_bit, // loop range bit
   output reg loop_active, // core clocked by the loop
   output reg [7:0] twi_clk_div, // two-wire bit clock divider
   output reg watchdog_en, // watchdog timer enabled
   output reg host_strobe_active_high, // host strobes active high
   output reg host_8bit, // host port in 8-bit mode
   output reg host_dual_strobe, // host port uses dual strobes
   output reg host_dma_en, // host port dma path enabled
   output reg host_irq_en, // host port interrupts enabled
   output reg host_word_lsb0 // host data bit 0 is the lsb
);
   wire por_s;
   wire hrst_s;
   wire wd_s;
   wire pol_s;
   wire w8_s;
   wire dual_s;
   wire [3:0] mode_s;
   wire capture_now;
   reg por_q;
   reg [2:0] port_d;
   reg [1:0] div_d;
   reg [5:0] mul_d;
   reg [1:0] sel_d;
   reg range_d;
   reg [7:0] tdiv_d;
   reg rsv_d;

   // straps and reset pins are asynchronous to core_clk
   // bits synced one by one: straps must be steady around release
   sync2 sync_por (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(power_on_reset_n),
      .q(por_s)
   );

   sync2 sync_hrst (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(hard_reset_n),
      .q(hrst_s)
   );

   sync2 sync_mode0 (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(boot_mode_straps[0]),
      .q(mode_s[0])
   );

   sync2 sync_mode1 (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(boot_mode_straps[1]),
      .q(mode_s[1])
   );

   sync2 sync_mode2 (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(boot_mode_straps[2]),
      .q(mode_s[2])
   );

   sync2 sync_mode3 (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(boot_mode_straps[3]),
      .q(mode_s[3])
   );

   sync2 sync_wd (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(watchdog_enable_strap),
      .q(wd_s)
   );

   sync2 sync_pol (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(host_strobe_polarity_strap),
      .q(pol_s)
   );

   sync2 sync_w8 (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(host_width_strap),
      .q(w8_s)
   );

   sync2 sync_dual (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .d(host_dual_strobe_strap),
      .q(dual_s)
   );

   // rising edge of the synced power-on reset: the only capture point
   assign capture_now = por_s && !por_q;

   // decode from the synchronised straps; only latched at release
   always @* begin
      port_d = `PORT_RESERVED;
      div_d = `DIV_NONE;
      mul_d = `MUL_NONE;
      sel_d = `SRC_SEL_00;
      range_d = 1'b0;
      tdiv_d = `TWI_NO_DIV;
      rsv_d = 1'b0;
      case (mode_s)
         `MODE_HOST_NOLOOP: begin
            port_d = `PORT_HOST;
         end

         `MODE_HOST_D1M12: begin
            port_d = `PORT_HOST;
            div_d = `DIV_1;
            mul_d = `MUL_12;
            sel_d = `SRC_SEL_11;
            range_d = 1'b1;
         end

         `MODE_HOST_D2M32: begin
            port_d = `PORT_HOST;
            div_d = `DIV_2;
            mul_d = `MUL_32;
            sel_d = `SRC_SEL_01;
            range_d = 1'b1;
         end

         `MODE_HOST_D3M12: begin
            port_d = `PORT_HOST;
            div_d = `DIV_3;
            mul_d = `MUL_12;
            sel_d = `SRC_SEL_11;
            range_d = 1'b1;
         end

         `MODE_HOST_D2M12: begin
            port_d = `PORT_HOST;
            div_d = `DIV_2;
            mul_d = `MUL_12;
            sel_d = `SRC_SEL_11;
            range_d = 1'b1;
         end

         `MODE_FLASH_NOLOOP: begin
            port_d = `PORT_FLASH_MAIN;
         end

         `MODE_FLASH_D1M17: begin
            port_d = `PORT_FLASH_MAIN;
            div_d = `DIV_1;
            mul_d = `MUL_17;
            sel_d = `SRC_SEL_11;
         end

         `MODE_FLASH_D2M16: begin
            port_d = `PORT_FLASH_MAIN;
            div_d = `DIV_2;
            mul_d = `MUL_16;
            sel_d = `SRC_SEL_11;
         end

         `MODE_FLASH_D3M18: begin
            port_d = `PORT_FLASH_MAIN;
            div_d = `DIV_3;
            mul_d = `MUL_18;
            sel_d = `SRC_SEL_11;
         end

         `MODE_FLASH_ALT: begin
            port_d = `PORT_FLASH_ALT;
         end

         `MODE_TWI: begin
            port_d = `PORT_TWI;
            tdiv_d = `TWI_CLK_DIV;
         end

         default: begin
            rsv_d = 1'b1;
         end
      endcase
   end

   // valid drops while held in power-on reset, rises at release
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         por_q <= 1'b0;
         straps_valid <= 1'b0;
      end else begin
         por_q <= por_s;
         if (!por_s) begin
            straps_valid <= 1'b0;
         end else if (capture_now) begin
            straps_valid <= 1'b1;
         end
      end
   end

   // boot port and clock fields keep their value until the next release
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_mode <= `MODE_RESET;
         boot_port <= `PORT_RESERVED;
         boot_mode_reserved <= 1'b0;
         loop_divide <= `DIV_NONE;
         loop_multiply <= `MUL_NONE;
         clock_source_select <= `SRC_SEL_00;
         loop_range_bit <= 1'b0;
         twi_clk_div <= `TWI_NO_DIV;
      end else if (capture_now) begin
         boot_mode <= mode_s;
         boot_port <= port_d;
         boot_mode_reserved <= rsv_d;
         loop_divide <= div_d;
         loop_multiply <= mul_d;
         clock_source_select <= sel_d;
         loop_range_bit <= range_d;
         twi_clk_div <= tdiv_d;
      end
   end

   // host port and watchdog straps; hard reset never reaches these
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_en <= 1'b0;
         host_strobe_active_high <= 1'b0;
         host_8bit <= 1'b0;
         host_dual_strobe <= 1'b0;
         host_dma_en <= 1'b0;
         host_irq_en <= 1'b0;
         host_word_lsb0 <= 1'b1;
      end else begin
         host_word_lsb0 <= 1'b1;
         // boot runs the port polled and without its dma path
         host_dma_en <= 1'b0;
         host_irq_en <= 1'b0;
         if (capture_now) begin
            watchdog_en <= (wd_s == `WDOG_ON);
            host_strobe_active_high <= (pol_s == `STROBE_HIGH);
            host_8bit <= (w8_s == `WIDTH_8BIT);
            host_dual_strobe <= (dual_s == `DUAL_STROBE);
         end
      end
   end

   // loop only if the captured code gave it a divider; no-loop codes
   // ignore the software request rather than run on a bad setting
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         loop_active <= 1'b0;
      end else if (!por_s || capture_now) begin
         loop_active <= 1'b0;
      end else if (!hrst_s) begin
         loop_active <= 1'b0;
      end else if (loop_enable_sw && straps_valid
                   && loop_divide != `DIV_NONE) begin
         loop_active <= 1'b1;
      end
   end
endmodule // strap_decoder
`default_nettype wire

/* File: test/strap_checker_assertions.sv */
// assertion checker on the strap decoder ports
`timescale 1ns/10ps
`default_nettype none
module strap_checker (
   input wire logic core_clk, // clock
   input wire logic arst_n, // reset
   input wire logic power_on_reset_n, // por pin
   input wire logic hard_reset_n, // hard reset pin
   input wire logic straps_valid, // captured
   input wire logic [3:0] boot_mode, // code
   input wire logic [2:0] boot_port, // port
   input wire logic boot_mode_reserved, // reserved
   input wire logic loop_active, // on loop
   input wire logic [7:0] twi_clk_div, // divider
   input wire logic watchdog_en, // watchdog
   input wire logic host_8bit, // width
   input wire logic host_dma_en, // dma
   input wire logic host_irq_en, // irq
   input wire logic host_word_lsb0 // bit order
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   a_capture_on_time: assert property ($rose(power_on_reset_n) ##1
      power_on_reset_n [*2] |-> ##[0:1] straps_valid) else $error("late");
   a_config_held: assert property (straps_valid && $past(straps_valid)
      |-> $stable(boot_mode) && $stable(host_8bit) && $stable(watchdog_en))
      else $error("config moved");
   a_loop_bypassed: assert property ($rose(straps_valid) |-> !loop_active)
      else $error("loop on at boot");
   a_hard_stops_loop: assert property (!hard_reset_n [*4] |-> !loop_active)
      else $error("loop on in hard reset");
   a_reserved_idle: assert property (boot_mode_reserved
      |-> boot_port == 3'h0 && !loop_active) else $error("reserved port");
   a_twi_divider: assert property (straps_valid && boot_mode == 4'h1
      |-> boot_port == 3'h4 && twi_clk_div == 8'h80) else $error("twi");
   a_host_polled: assert property (!host_dma_en && !host_irq_en)
      else $error("dma or irq on");
   a_lsb_first: assert property (host_word_lsb0)
      else $error("bit order");
endmodule // strap_checker
bind strap_decoder strap_checker strap_checker_inst (.*);
`default_nettype wire

/* File: test/board_straps.sv */
// board strap model: holds straps through power-on reset, then floats
`timescale 1ns/10ps
`default_nettype none
module board_straps (
   input wire logic core_clk, // clock
   input wire logic power_on_reset_n, // por pin
   input wire logic [7:0] cfg, // levels to present
   output logic [3:0] boot_mode_straps, // mode pins
   output logic watchdog_enable_strap, // strap
   output logic host_strobe_polarity_strap, // strap
   output logic host_width_strap, // strap
   output logic host_dual_strobe_strap // strap
);
   int held = 0;
   always @(posedge core_clk) begin
      held <= power_on_reset_n ? held + 1 : 0;
   end
   // floating pins shown inverted so a late recapture is visible
   assign {boot_mode_straps, watchdog_enable_strap, host_strobe_polarity_strap,
      host_width_strap, host_dual_strobe_strap} = held > 6 ? ~cfg : cfg;
endmodule // board_straps
`default_nettype wire

/* File: test/strap_decoder_tb.sv */
// self-checking bench for the strap decoder
`timescale 1ns/10ps
`default_nettype none
module strap_decoder_tb;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic power_on_reset_n = 1'b0;
   logic hard_reset_n = 1'b1;
   logic loop_enable_sw = 1'b0;
   logic [7:0] cfg = 8'h00;
   wire [3:0] boot_mode_straps, boot_mode;
   wire watchdog_enable_strap, host_strobe_polarity_strap, host_width_strap;
   wire host_dual_strobe_strap, straps_valid, boot_mode_reserved;
   wire loop_range_bit, loop_active, watchdog_en, host_strobe_active_high;
   wire host_8bit, host_dual_strobe, host_dma_en, host_irq_en, host_word_lsb0;
   wire [2:0] boot_port;
   wire [1:0] loop_divide, clock_source_select;
   wire [5:0] loop_multiply;
   wire [7:0] twi_clk_div;
   int errors = 0;
   int check_count = 0;
   always #20 core_clk = ~core_clk;
   board_straps board_straps_inst (.*);
   strap_decoder strap_decoder_inst (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic boot(input logic [7:0] c);
      @(negedge core_clk);
      power_on_reset_n = 1'b0;
      cfg = c;
      repeat (5) @(negedge core_clk);
      power_on_reset_n = 1'b1;
      repeat (5) @(negedge core_clk);
   endtask
   // port, divide, multiply, select, range, two-wire divider
   function automatic logic [21:0] decode(input logic [3:0] m);
      case (m)
         4'h0: decode = {3'h1, 2'h0, 6'h00, 2'h0, 1'h0, 8'h00};
         4'h1: decode = {3'h4, 2'h0, 6'h00, 2'h0, 1'h0, 8'h80};
         4'h2: decode = {3'h1, 2'h2, 6'h20, 2'h1, 1'h1, 8'h00};
         4'h4: decode = {3'h1, 2'h2, 6'h0C, 2'h3, 1'h1, 8'h00};
         4'h5: decode = {3'h1, 2'h1, 6'h0C, 2'h3, 1'h1, 8'h00};
         4'h7: decode = {3'h1, 2'h3, 6'h0C, 2'h3, 1'h1, 8'h00};
         4'h8: decode = {3'h2, 2'h0, 6'h00, 2'h0, 1'h0, 8'h00};
         4'h9: decode = {3'h2, 2'h1, 6'h11, 2'h3, 1'h0, 8'h00};
         4'hA: decode = {3'h2, 2'h2, 6'h10, 2'h3, 1'h0, 8'h00};
         4'hB: decode = {3'h2, 2'h3, 6'h12, 2'h3, 1'h0, 8'h00};
         4'hC: decode = {3'h3, 2'h0, 6'h00, 2'h0, 1'h0, 8'h00};
         default: decode = 22'h000000;
      endcase
   endfunction
   task automatic codes_scan();
      logic [3:0] m;
      for (int i = 0; i < 16; i++) begin
         m = 4'(i);
         boot({m, m ^ 4'h6});
         chk(32'({boot_port, loop_divide, loop_multiply, clock_source_select,
            loop_range_bit, twi_clk_div}), 32'(decode(m)));
         chk(32'({boot_mode_reserved, loop_active, boot_mode}),
            32'({decode(m) == 22'h000000, 1'b0, m}));
         chk(32'({watchdog_en, host_strobe_active_high, host_8bit,
            host_dual_strobe}), 32'(m ^ 4'h6));
      end
   endtask
   task automatic loop_hard_reset();
      boot(8'h5A);
      loop_enable_sw = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(32'(loop_active), 32'h00000001);
      hard_reset_n = 1'b0;
      repeat (8) @(negedge core_clk);
      chk(32'({loop_active, boot_mode, host_8bit}), 32'h0000000B);
      hard_reset_n = 1'b1;
      boot(8'h00);
      chk(32'(loop_active), 32'h00000000);
      loop_enable_sw = 1'b0;
   endtask
   // host boot: poll for capture, then four 16-bit words, top first
   task automatic host_boot();
      logic [63:0] image;
      logic [15:0] word;
      int n;
      image = 64'h0123456789ABCDEF;
      boot(8'h00);
      n = 0;
      while (!straps_valid && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      chk(32'({straps_valid, host_dma_en, host_irq_en, host_8bit}),
         32'h00000008);
      for (int w = 3; w >= 0; w--) begin
         word = image[w*16 +: 16];
         @(negedge core_clk);
         chk(32'({host_8bit, host_word_lsb0, word}),
            32'({2'b01, image[w*16 +: 16]}));
      end
   endtask
   task automatic wrap_up();
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge core_clk);
      arst_n = 1'b1;
      codes_scan();
      loop_hard_reset();
      host_boot();
      wrap_up();
   end
   // about 245 cycles expected; generous margin
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
endmodule // strap_decoder_tb
`default_nettype wire
